// file: design/usf_pkg.sv
// Package of register map, field positions and reset values for status flags
package usf_pkg;

    localparam int unsigned AW = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_STAT  = 8'h00;
    localparam logic [7:0] ADDR_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_RXBUF = 8'h08;
    localparam logic [7:0] ADDR_TXBUF = 8'h0C;
    localparam logic [7:0] ADDR_IST   = 8'h10;
    localparam logic [7:0] ADDR_IMASK = 8'h14;

    // Status register field positions
    localparam int unsigned ST_TXE  = 7;
    localparam int unsigned ST_RXF  = 6;
    localparam int unsigned ST_OVR  = 5;
    localparam int unsigned ST_FER  = 4;
    localparam int unsigned ST_PER  = 3;
    localparam int unsigned ST_TRANSMIT_END_FLAG = 2;
    localparam int unsigned ST_LO   = 3;
    localparam logic [7:0]  STAT_RST = 8'h84;

    // Control register field positions
    localparam int unsigned CT_RX_ON  = 0;
    localparam int unsigned CT_TX_ON  = 1;
    localparam int unsigned CT_PAR_EN = 2;
    localparam int unsigned CT_ODD    = 3;
    localparam int unsigned CT_SYNC   = 4;
    localparam int unsigned CT_W      = 5;
    localparam logic [4:0]  CTRL_RST  = 5'h00;

    // Interrupt status / mask field positions
    localparam int unsigned IR_RXF  = 0;
    localparam int unsigned IR_OVR  = 1;
    localparam int unsigned IR_FER  = 2;
    localparam int unsigned IR_PER  = 3;
    localparam int unsigned IR_TRANSMIT_END_FLAG = 4;
    localparam int unsigned IR_W    = 5;
    localparam logic [4:0]  IR_RST  = 5'h00;

endpackage : usf_pkg

// file: design/usf_chk_if.sv
// Interface carrying a finished receive character to the error checker
`timescale 1ns/1ns
interface usf_chk_if #(
    parameter int unsigned DW = 8
);
    logic [DW-1:0] data;
    logic          parity_bit;
    logic          stop_bit;
    logic          parity_en;
    logic          parity_odd_select;
    logic          sync_mode;
    logic          fer_hit;
    logic          per_hit;

    modport ctl (
        output data,
        output parity_bit,
        output stop_bit,
        output parity_en,
        output parity_odd_select,
        output sync_mode,
        input  fer_hit,
        input  per_hit
    );

    modport chk (
        input  data,
        input  parity_bit,
        input  stop_bit,
        input  parity_en,
        input  parity_odd_select,
        input  sync_mode,
        output fer_hit,
        output per_hit
    );
endinterface : usf_chk_if

// file: design/usf_rx_check.sv
// Framing and parity check of one received character
`timescale 1ns/1ns
module usf_rx_check (
    usf_chk_if.chk chk
);
    logic ones_odd;

    always_comb
    begin
        ones_odd    = ^{chk.data, chk.parity_bit};
        // Only the first stop bit is presented; a second one is never seen
        chk.fer_hit = !chk.sync_mode && !chk.stop_bit;        // [R9] [R10]
        chk.per_hit = !chk.sync_mode && chk.parity_en &&
                      (ones_odd != chk.parity_odd_select);    // [R13]
    end
endmodule : usf_rx_check

// file: design/usf_status.sv
// Serial status flags with APB register access and interrupt
//
// Operation
// [R1] Clean character moves into receive buffer and sets receive-full flag.
// [R2] Receive-full clears on armed write of 0 or receive buffer read.
// [R3] Errors or receiver off leave buffer and receive-full unchanged.
// [R4] Character ending while receive-full set raises overrun, is discarded.
// [R5] After overrun buffer keeps old character; later characters are lost.
// [R6] Overrun stops reception; in synchronous mode also transmission.
// [R7] Overrun, framing, parity flags clear only by armed write of 0.
// [R8] Receiver disable leaves overrun, framing and parity flags alone.
// [R9] Asynchronous stop bit of 0 sets framing-error flag.
// [R10] With two stop bits only the first is checked.
// [R11] Framing error copies character but leaves receive-full clear.
// [R12] Framing error stops reception; synchronous mode blocks both ways.
// [R13] Enabled asynchronous parity mismatch sets parity-error flag.
// [R14] Parity error copies character, no receive-full, stops reception.
// [R15] Transmit-end sets on last bit with empty flag, or tx disable.
// [R16] Transmit-end clears on armed empty-flag write 0 or buffer write.
// [R17] Transmit-end read-only, resets to 1; other flags reset to 0 (code also resets transmit-empty to 1).
// [R18] Writing 1 to clearable flags does nothing.
// [R19] Transmit-empty sets when buffer moves into transmit shift register.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
module usf_status #(
    parameter int unsigned DW = 8
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [usf_pkg::AW-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   rx_done,
    input  wire logic [DW-1:0]          rx_data,
    input  wire logic                   rx_parity_bit,
    input  wire logic                   rx_stop_bit,
    input  wire logic                   tx_load,
    input  wire logic                   tx_last_bit,
    output logic      [DW-1:0]          tx_data,
    output logic                        tx_pending,
    output logic                        rx_halt,
    output logic                        tx_halt,
    output logic                        irq
);
    localparam int unsigned NW = 32 - DW;
    localparam int unsigned CW = usf_pkg::CT_W;
    localparam int unsigned IW = usf_pkg::IR_W;

    logic [31:0]   prdata_q;
    logic [31:0]   rdval;
    logic          pready_q;
    logic          pslverr_q;
    logic          hit;
    logic          acc;
    logic          wr;
    logic          rd;
    logic [CW-1:0] ctrl_q;
    logic          tx_on_prev_q;
    logic [IW-1:0] mask_q;
    logic [IW-1:0] ist_q;
    logic [IW-1:0] ist_d;
    logic [IW-1:0] ev;
    logic [7:0]    stat;
    logic [7:3]    arm_q;
    logic [7:3]    clr;
    logic          txe_q;
    logic          txe_d;
    logic          rxf_q;
    logic          rxf_d;
    logic          ovr_q;
    logic          ovr_d;
    logic          fer_q;
    logic          fer_d;
    logic          per_q;
    logic          per_d;
    logic          transmit_end_flag_q;
    logic          transmit_end_flag_d;
    logic [DW-1:0] rx_buf_q;
    logic [DW-1:0] tx_data_q;
    logic          tx_pending_q;
    logic          rx_halt_q;
    logic          tx_halt_q;
    logic          irq_q;
    logic          rx_go;
    logic          rx_ok;
    logic          ovr_set;
    logic          fer_set;
    logic          per_set;
    logic          good;
    logic          tx_off;
    logic          transmit_end_flag_set;
    logic          rd_rxbuf;
    logic          wr_txbuf;

    usf_chk_if #(.DW(DW)) chk_if ();

    usf_rx_check u_check (
        .chk (chk_if.chk)
    );

    assign chk_if.data              = rx_data;
    assign chk_if.parity_bit        = rx_parity_bit;
    assign chk_if.stop_bit          = rx_stop_bit;
    assign chk_if.parity_en         = ctrl_q[usf_pkg::CT_PAR_EN];
    assign chk_if.parity_odd_select = ctrl_q[usf_pkg::CT_ODD];
    assign chk_if.sync_mode         = ctrl_q[usf_pkg::CT_SYNC];

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign tx_data    = tx_data_q;
    assign tx_pending = tx_pending_q;
    assign rx_halt    = rx_halt_q;
    assign tx_halt    = tx_halt_q;
    assign irq        = irq_q;

    // Bus decode; no wait states, read data is taken into a flop in the setup phase
    assign acc      = psel && penable && pready_q;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    assign rd_rxbuf = rd && (paddr == usf_pkg::ADDR_RXBUF);
    assign wr_txbuf = wr && (paddr == usf_pkg::ADDR_TXBUF);

    assign stat = {txe_q, rxf_q, ovr_q, fer_q, per_q, transmit_end_flag_q, 2'b00};

    always_comb
    begin
        hit   = 1'b1;
        rdval = 32'h0000_0000;
        unique case (paddr)
            usf_pkg::ADDR_STAT:  rdval = {24'h00_0000, stat};
            usf_pkg::ADDR_CTRL:  rdval = {{(32-CW){1'b0}}, ctrl_q};
            usf_pkg::ADDR_RXBUF: rdval = {{NW{1'b0}}, rx_buf_q};
            usf_pkg::ADDR_TXBUF: rdval = {{NW{1'b0}}, tx_data_q};
            usf_pkg::ADDR_IST:   rdval = {{(32-IW){1'b0}}, ist_q};
            usf_pkg::ADDR_IMASK: rdval = {{(32-IW){1'b0}}, mask_q};
            default:             hit   = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !hit;
            if (psel && !penable && !pwrite)
                prdata_q <= rdval;
        end
    end

    // Control and mask registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q       <= usf_pkg::CTRL_RST;
            mask_q       <= usf_pkg::IR_RST;
            tx_on_prev_q <= 1'b0;
        end
        else
        begin
            tx_on_prev_q <= ctrl_q[usf_pkg::CT_TX_ON];
            if (wr && paddr == usf_pkg::ADDR_CTRL)
                ctrl_q <= pwdata[CW-1:0];
            if (wr && paddr == usf_pkg::ADDR_IMASK)
                mask_q <= pwdata[IW-1:0];
        end
    end

    // A clear by 0 needs the flag to have been read as 1 first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            arm_q <= 5'h00;
        else if (rd && paddr == usf_pkg::ADDR_STAT)
            arm_q <= arm_q | prdata_q[7:3];
        else if (wr && paddr == usf_pkg::ADDR_STAT)
            arm_q <= arm_q & pwdata[7:3];
    end

    // Bits written 1 leave the flag alone
    assign clr = (wr && paddr == usf_pkg::ADDR_STAT) ?
                 (arm_q & ~pwdata[7:3]) : 5'h00;                    // [R18]

    // Receive events; an error flag blocks further characters
    assign rx_go   = rx_done && ctrl_q[usf_pkg::CT_RX_ON] &&
                     !(ovr_q || fer_q || per_q);           // [R3] [R6] [R12]
    assign ovr_set = rx_go && rxf_q;                                 // [R4]
    assign rx_ok   = rx_go && !rxf_q;                                // [R5]
    assign fer_set = rx_ok && chk_if.fer_hit;                        // [R9]
    assign per_set = rx_ok && chk_if.per_hit;                        // [R13]
    assign good    = rx_ok && !chk_if.fer_hit && !chk_if.per_hit;    // [R1]

    // Transmit events
    assign tx_off   = tx_on_prev_q && !ctrl_q[usf_pkg::CT_TX_ON];
    assign transmit_end_flag_set = (tx_last_bit && txe_q) || tx_off;              // [R15]

    // Flag next values; a set always wins over a clear
    always_comb
    begin
        rxf_d  = rxf_q;
        ovr_d  = ovr_q;
        fer_d  = fer_q;
        per_d  = per_q;
        txe_d  = txe_q;
        transmit_end_flag_d = transmit_end_flag_q;
        if (good)
            rxf_d = 1'b1;                                            // [R1]
        else if (clr[usf_pkg::ST_RXF] || rd_rxbuf)
            rxf_d = 1'b0;                                            // [R2]
        if (ovr_set)
            ovr_d = 1'b1;                                            // [R4]
        else if (clr[usf_pkg::ST_OVR])
            ovr_d = 1'b0;                                       // [R7] [R8]
        if (fer_set)
            fer_d = 1'b1;                                            // [R9]
        else if (clr[usf_pkg::ST_FER])
            fer_d = 1'b0;                                       // [R7] [R8]
        if (per_set)
            per_d = 1'b1;                                            // [R13]
        else if (clr[usf_pkg::ST_PER])
            per_d = 1'b0;                                       // [R7] [R8]
        if (tx_load || tx_off)
            txe_d = 1'b1;                                            // [R19]
        else if (clr[usf_pkg::ST_TXE] || wr_txbuf)
            txe_d = 1'b0;
        if (transmit_end_flag_set)
            transmit_end_flag_d = 1'b1;                                           // [R15]
        else if (clr[usf_pkg::ST_TXE] || wr_txbuf)
            transmit_end_flag_d = 1'b0;                                           // [R16]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txe_q  <= usf_pkg::STAT_RST[usf_pkg::ST_TXE];            // [R17]
            rxf_q  <= usf_pkg::STAT_RST[usf_pkg::ST_RXF];
            ovr_q  <= usf_pkg::STAT_RST[usf_pkg::ST_OVR];
            fer_q  <= usf_pkg::STAT_RST[usf_pkg::ST_FER];
            per_q  <= usf_pkg::STAT_RST[usf_pkg::ST_PER];
            transmit_end_flag_q <= usf_pkg::STAT_RST[usf_pkg::ST_TRANSMIT_END_FLAG];
        end
        else
        begin
            txe_q  <= txe_d;
            rxf_q  <= rxf_d;
            ovr_q  <= ovr_d;
            fer_q  <= fer_d;
            per_q  <= per_d;
            transmit_end_flag_q <= transmit_end_flag_d;
        end
    end

    // Receive buffer; errored characters still land here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_buf_q <= '0;
        else if (rx_ok)
            rx_buf_q <= rx_data;                           // [R1] [R11] [R14]
    end

    // Transmit buffer and link-side outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_data_q    <= '0;
            tx_pending_q <= 1'b0;
            rx_halt_q    <= 1'b0;
            tx_halt_q    <= 1'b0;
        end
        else
        begin
            if (wr_txbuf)
                tx_data_q <= pwdata[DW-1:0];
            tx_pending_q <= !txe_d;
            rx_halt_q    <= ovr_d || fer_d || per_d;        // [R6] [R12] [R14]
            tx_halt_q    <= ctrl_q[usf_pkg::CT_SYNC] &&
                            (ovr_d || fer_d || per_d);          // [R6] [R12]
        end
    end

    // Sticky interrupt status, write 1 to clear, event wins
    assign ev[usf_pkg::IR_RXF]  = good;
    assign ev[usf_pkg::IR_OVR]  = ovr_set;
    assign ev[usf_pkg::IR_FER]  = fer_set;
    assign ev[usf_pkg::IR_PER]  = per_set;
    assign ev[usf_pkg::IR_TRANSMIT_END_FLAG] = transmit_end_flag_set && !transmit_end_flag_q;

    always_comb
    begin
        ist_d = ist_q;
        if (wr && paddr == usf_pkg::ADDR_IST)
            ist_d = ist_q & ~pwdata[IW-1:0];
        ist_d = ist_d | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_q <= usf_pkg::IR_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d;
            irq_q <= |(ist_d & mask_q);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_rxf_set: assert property (good |=> rxf_q)                      // [R1]
        else $error("receive-full not set after clean character");
    a_rxf_rdclr: assert property (rd_rxbuf && !good |=> !rxf_q)      // [R2]
        else $error("receive-full not cleared by buffer read");
    a_ovr_keep: assert property (ovr_set |=> ovr_q && !rxf_d == !rxf_q
        && $stable(rx_buf_q))                                   // [R4] [R5]
        else $error("overrun did not keep buffer");
    a_halt_flags: assert property (ovr_q || fer_q || per_q
        |-> rx_halt_q && (tx_halt_q == ctrl_q[usf_pkg::CT_SYNC])) // [R6] [R12]
        else $error("reception not halted on error flag");
    a_err_block: assert property ((ovr_q || fer_q || per_q) && rx_done
        |=> $stable(rx_buf_q))                                      // [R3]
        else $error("buffer changed while reception blocked");
    a_fer_copy: assert property (fer_set |=> fer_q && !rxf_q
        && rx_buf_q == $past(rx_data))                         // [R9] [R11]
        else $error("framing error handling wrong");
    a_per_copy: assert property (per_set |=> per_q && !rxf_q
        && rx_buf_q == $past(rx_data))                        // [R13] [R14]
        else $error("parity error handling wrong");
    a_transmit_end_flag_off: assert property ($fell(ctrl_q[usf_pkg::CT_TX_ON])
        |-> ##1 transmit_end_flag_q && txe_q)                               // [R15] [R19]
        else $error("transmit-end not set on transmitter disable");
    a_transmit_end_flag_clr: assert property (wr_txbuf && !transmit_end_flag_set && !tx_load
        |=> !transmit_end_flag_q && !txe_q)                                      // [R16]
        else $error("transmit buffer write did not clear flags");
    a_one_noeff: assert property (wr && paddr == usf_pkg::ADDR_STAT
        && pwdata[7:3] == 5'h1F |=> !$fell(ovr_q) && !$fell(fer_q)
        && !$fell(per_q))                                      // [R7] [R18]
        else $error("write of one changed a flag");
    a_rx_off_keep: assert property (!ctrl_q[usf_pkg::CT_RX_ON] && !clr[5]
        && !clr[4] && !clr[3] |=> $stable({ovr_q, fer_q, per_q}))   // [R8]
        else $error("flags changed with receiver off");

    c_overrun: cover property (ovr_set);
    c_framing: cover property (fer_set);
    c_transmit_end_flag:    cover property (transmit_end_flag_set && !transmit_end_flag_q);
    c_irq:     cover property ($rose(irq_q));
endmodule : usf_status

// file: bench/usf_link_model.sv
// Remote serial station model driving link events into the status block
`timescale 1ns/1ns
module usf_link_model (
    input  wire logic       pclk,
    output logic            rx_done,
    output logic [7:0]      rx_data,
    output logic            rx_parity_bit,
    output logic            rx_stop_bit,
    output logic            tx_load,
    output logic            tx_last_bit
);
    initial
    begin
        rx_done       = 1'b0;
        rx_data       = 8'h00;
        rx_parity_bit = 1'b0;
        rx_stop_bit   = 1'b1;
        tx_load       = 1'b0;
        tx_last_bit   = 1'b0;
    end

    // One finished character; lines scrambled once the pulse is over
    task automatic send_rx(
        input logic [7:0] d,
        input logic       par,
        input logic       stop
    );
        @(posedge pclk);
        rx_done       <= 1'b1;
        rx_data       <= d;
        rx_parity_bit <= par;
        rx_stop_bit   <= stop;
        @(posedge pclk);
        rx_done       <= 1'b0;
        rx_data       <= ~d;
        rx_parity_bit <= ~par;
        rx_stop_bit   <= ~stop;
    endtask : send_rx

    // Transmit pulse: sel 1 last bit, sel 0 buffer into shifter
    task automatic tx_pulse(input logic sel);
        @(posedge pclk);
        tx_last_bit <= sel;
        tx_load     <= ~sel;
        @(posedge pclk);
        tx_last_bit <= 1'b0;
        tx_load     <= 1'b0;
    endtask : tx_pulse
endmodule : usf_link_model

// file: bench/tb_uart_status_flags.sv
// Self-checking testbench of the serial status flag block
`timescale 1ns/1ns
module tb_uart_status_flags;
    localparam logic [7:0] A_ST = usf_pkg::ADDR_STAT;
    localparam logic [7:0] A_CT = usf_pkg::ADDR_CTRL;
    localparam logic [7:0] A_RX = usf_pkg::ADDR_RXBUF;
    localparam logic [7:0] A_TX = usf_pkg::ADDR_TXBUF;
    localparam logic [7:0] A_IS = usf_pkg::ADDR_IST;
    localparam logic [7:0] A_IM = usf_pkg::ADDR_IMASK;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_done;
    logic [7:0]  rx_data;
    logic        rx_parity_bit;
    logic        rx_stop_bit;
    logic        tx_load;
    logic        tx_last_bit;
    logic [7:0]  tx_data;
    logic        tx_pending;
    logic        rx_halt;
    logic        tx_halt;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          checked;

    usf_status #(.DW(8)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_done, .rx_data, .rx_parity_bit,
        .rx_stop_bit, .tx_load, .tx_last_bit, .tx_data, .tx_pending,
        .rx_halt, .tx_halt, .irq
    );

    usf_link_model lnk (
        .pclk, .rx_done, .rx_data, .rx_parity_bit, .rx_stop_bit,
        .tx_load, .tx_last_bit
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 16)
            chk(1'b0, 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    // Let registered outputs land
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task automatic wrap_up;
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        wrap_up();
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        fails   = 0;
        checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(A_ST, 32'h84);
        rdchk(A_CT, 32'h00);
        lnk.send_rx(8'h5A, 1'b0, 1'b1);
        rdchk(A_ST, 32'h84);
        wr(A_CT, 32'h01);
        lnk.send_rx(8'h5A, 1'b0, 1'b1);
        rdchk(A_ST, 32'hC4);
        rdchk(A_RX, 32'h5A);
        rdchk(A_ST, 32'h84);
        // Overrun, unarmed clear, receiver off, blocked reception
        lnk.send_rx(8'h11, 1'b0, 1'b1);
        lnk.send_rx(8'h22, 1'b0, 1'b1);
        wr(A_ST, 32'hDF);
        rdchk(A_ST, 32'hE4);
        chk(rx_halt, 1'b1);
        wr(A_CT, 32'h00);
        rdchk(A_ST, 32'hE4);
        wr(A_ST, 32'hFF);
        rdchk(A_ST, 32'hE4);
        rdchk(A_RX, 32'h11);
        wr(A_CT, 32'h01);
        lnk.send_rx(8'h33, 1'b0, 1'b1);
        rdchk(A_ST, 32'hA4);
        wr(A_ST, 32'hDF);
        rdchk(A_ST, 32'h84);
        rdchk(A_RX, 32'h11);
        // Framing error
        lnk.send_rx(8'h3C, 1'b0, 1'b0);
        rdchk(A_ST, 32'h94);
        rdchk(A_RX, 32'h3C);
        lnk.send_rx(8'h44, 1'b0, 1'b1);
        rdchk(A_ST, 32'h94);
        chk(rx_halt, 1'b1);
        wr(A_ST, 32'hEF);
        rdchk(A_ST, 32'h84);
        // Parity even and odd, good and bad
        for (int i = 0; i < 4; i++)
        begin
            wr(A_CT, {28'h0, i[1], 3'b101});
            lnk.send_rx(8'(8'h07 << i), i[0], 1'b1);
            rdchk(A_ST, (i[0] == i[1]) ? 32'h8C : 32'hC4);
            rdchk(A_RX, 32'h07 << i);
            wr(A_ST, 32'hF7);
            rdchk(A_ST, 32'h84);
        end
        // Synchronous: no framing check, overrun halts transmit
        wr(A_CT, 32'h13);
        lnk.send_rx(8'h3C, 1'b0, 1'b0);
        rdchk(A_ST, 32'hC4);
        lnk.send_rx(8'h55, 1'b0, 1'b1);
        rdchk(A_ST, 32'hE4);
        chk(tx_halt, 1'b1);
        rdchk(A_RX, 32'h3C);
        wr(A_ST, 32'hDF);
        settle();
        chk(tx_halt, 1'b0);
        // Transmit side
        wr(A_TX, 32'hA5);
        settle();
        chk(tx_data, 8'hA5);
        chk(tx_pending, 1'b1);
        rdchk(A_ST, 32'h00);
        lnk.tx_pulse(1'b1);
        rdchk(A_ST, 32'h00);
        lnk.tx_pulse(1'b0);
        rdchk(A_ST, 32'h80);
        lnk.tx_pulse(1'b1);
        rdchk(A_ST, 32'h84);
        wr(A_ST, 32'h7F);
        rdchk(A_ST, 32'h00);
        wr(A_ST, 32'hFF);
        rdchk(A_ST, 32'h00);
        wr(A_CT, 32'h00);
        settle();
        rdchk(A_ST, 32'h84);
        // Interrupt: masked, unmasked, cleared
        wr(A_CT, 32'h01);
        wr(A_IS, 32'h1F);
        rdchk(A_IS, 32'h00);
        lnk.send_rx(8'h6B, 1'b0, 1'b1);
        rdchk(A_IS, 32'h01);
        settle();
        chk(irq, 1'b0);
        wr(A_IM, 32'h01);
        settle();
        chk(irq, 1'b1);
        wr(A_IS, 32'h01);
        settle();
        chk(irq, 1'b0);
        // Unmapped address and read-only receive buffer
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        wr(A_RX, 32'h99);
        rdchk(A_RX, 32'h6B);
        wrap_up();
    end
endmodule : tb_uart_status_flags
